// File: include/srtc_pkg.sv
/*
  Package for the sleep, global reset and output tristate sequencer:
  timing constants, reset values and the pin-control carrier struct.
  Assumes a 200 MHz system clock.
*/
package srtc_pkg;

  // =========================================================
  // clock and timing
  // =========================================================
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SLEEP_ENTRY_DELAY_NS = 400;
  localparam int SLEEP_EXIT_DELAY_US = 400;
  localparam int LOAD_DELAY_US = 400;
  // all times round down; the entry time never below one cycle
  localparam int SLEEP_ENTRY_CYCLES =
    (SLEEP_ENTRY_DELAY_NS * 1000) / CLK_PERIOD_PS < 1 ? 1 :
    (SLEEP_ENTRY_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int SLEEP_EXIT_CYCLES = (SLEEP_EXIT_DELAY_US * 1000000) / CLK_PERIOD_PS;
  localparam int LOAD_CYCLES = (LOAD_DELAY_US * 1000000) / CLK_PERIOD_PS;
  localparam int CNT_W = 20;

  // =========================================================
  // reset values
  // =========================================================
  localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;

  // =========================================================
  // states
  // =========================================================
  typedef enum logic [4:0] {
    SRTC_ST_LOAD  = 5'h01,
    SRTC_ST_RUN   = 5'h02,
    SRTC_ST_ENTER = 5'h04,
    SRTC_ST_SLEEP = 5'h08,
    SRTC_ST_WAKE  = 5'h10
  } srtc_state_t;

  // =========================================================
  // pin-control carrier
  // =========================================================
  typedef struct packed {
    logic io_tristate;
    logic io_pullup;
    logic core_reset_n;
    logic core_powered;
  } srtc_ctrl_t;

  // pads float with pull-ups, core powered but held in reset, as while loading
  localparam srtc_ctrl_t CTRL_RST = 4'hD;

endpackage : srtc_pkg

// File: rtl/srtc_top.sv
/*
  Sequencer for sleep entry/exit, configuration load after supply valid,
  global reset and global output tristate of a small programmable part.
  Assumes sleep, reset and tristate pins are asynchronous board signals;
  pull-ups on pins are modelled by the pad ring outside.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - sleep low: powered down within 400 ns
// - sleep high: awake within density bound
// - sleep high means normal operation
// - tristate pin high floats every output
// - active-low global reset acts device-wide
// - configuration holds I/O tristated, pulled up (pull-up only with cfg_tristate_opt or erased)
// - erased device keeps I/O tristated, pulled
// - I/O active within load time after supplies
module srtc_top #(
  parameter int SLEEP_EXIT_CYCLES = srtc_pkg::SLEEP_EXIT_CYCLES,
  parameter int LOAD_CYCLES = srtc_pkg::LOAD_CYCLES
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // supply and configuration status
  input wire logic supplies_valid,
  input wire logic device_erased,
  input wire logic cfg_tristate_opt,
  // board control pins
  input wire logic sleep_request_n,
  input wire logic global_set_reset_n,
  input wire logic global_output_tristate,
  // controls to core and pad ring
  output srtc_pkg::srtc_ctrl_t ctrl,
  output logic io_active,
  output logic asleep
);

  // =========================================================
  // pin synchronisers
  // =========================================================
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] meta_nxt;
  logic [3:0] sync_nxt;

  always_comb
  begin
    meta_nxt = {supplies_valid, sleep_request_n, global_set_reset_n, global_output_tristate};
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      // sleep and reset pins idle high (pull-ups)
      meta_r <= 4'h6;
      sync_r <= 4'h6;
    end
    else if (clk_en)
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  logic sup_s;
  logic sleep_n_s;
  logic gsr_n_s;
  logic ts_s;
  assign {sup_s, sleep_n_s, gsr_n_s, ts_s} = sync_r;

  // =========================================================
  // sequencer
  // =========================================================
  srtc_pkg::srtc_state_t state_r;
  srtc_pkg::srtc_state_t state_nxt;
  logic [srtc_pkg::CNT_W-1:0] cnt_r;
  logic [srtc_pkg::CNT_W-1:0] cnt_nxt;

  function automatic logic [srtc_pkg::CNT_W-1:0] last_of(input int n);
    last_of = srtc_pkg::CNT_W'(n - 1);
  endfunction : last_of

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 20'h00001;
    unique case (state_r)
      srtc_pkg::SRTC_ST_LOAD:
      begin
        // load timer only runs once supplies are good
        if (!sup_s || device_erased)
          cnt_nxt = srtc_pkg::CNT_RST;
        else if (cnt_r == last_of(LOAD_CYCLES))
        begin
          state_nxt = srtc_pkg::SRTC_ST_RUN;
          cnt_nxt = srtc_pkg::CNT_RST;
        end
      end
      srtc_pkg::SRTC_ST_RUN:
      begin
        cnt_nxt = srtc_pkg::CNT_RST;
        if (!sleep_n_s)
          state_nxt = srtc_pkg::SRTC_ST_ENTER;
      end
      srtc_pkg::SRTC_ST_ENTER:
      begin
        // entry completes regardless of pin changes
        if (cnt_r == last_of(srtc_pkg::SLEEP_ENTRY_CYCLES))
        begin
          state_nxt = srtc_pkg::SRTC_ST_SLEEP;
          cnt_nxt = srtc_pkg::CNT_RST;
        end
      end
      srtc_pkg::SRTC_ST_SLEEP:
      begin
        cnt_nxt = srtc_pkg::CNT_RST;
        if (sleep_n_s)
          state_nxt = srtc_pkg::SRTC_ST_WAKE;
      end
      srtc_pkg::SRTC_ST_WAKE:
      begin
        if (cnt_r == last_of(SLEEP_EXIT_CYCLES))
        begin
          state_nxt = srtc_pkg::SRTC_ST_RUN;
          cnt_nxt = srtc_pkg::CNT_RST;
        end
      end
      default:
      begin
        state_nxt = srtc_pkg::SRTC_ST_LOAD;
        cnt_nxt = srtc_pkg::CNT_RST;
      end
    endcase
    // supply loss restarts configuration
    if (!sup_s)
    begin
      state_nxt = srtc_pkg::SRTC_ST_LOAD;
      cnt_nxt = srtc_pkg::CNT_RST;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_r <= srtc_pkg::SRTC_ST_LOAD;
      cnt_r <= srtc_pkg::CNT_RST;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // =========================================================
  // output controls
  // =========================================================
  srtc_pkg::srtc_ctrl_t ctrl_nxt;
  logic io_active_nxt;
  logic asleep_nxt;

  always_comb
  begin
    io_active_nxt = (state_nxt == srtc_pkg::SRTC_ST_RUN);
    asleep_nxt = (state_nxt == srtc_pkg::SRTC_ST_SLEEP);
    ctrl_nxt.core_powered = !asleep_nxt;
    ctrl_nxt.core_reset_n = gsr_n_s && io_active_nxt;
    ctrl_nxt.io_pullup = 1'b0;
    ctrl_nxt.io_tristate = 1'b0;
    if (state_nxt == srtc_pkg::SRTC_ST_LOAD)
    begin
      // option off on a non-erased device lets pads float without pull-up while loading
      ctrl_nxt.io_tristate = 1'b1;
      ctrl_nxt.io_pullup = cfg_tristate_opt || device_erased;
    end
    else if (!io_active_nxt || ts_s)
      ctrl_nxt.io_tristate = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ctrl <= srtc_pkg::CTRL_RST;
      io_active <= 1'b0;
      asleep <= 1'b0;
    end
    else if (clk_en)
    begin
      ctrl <= ctrl_nxt;
      io_active <= io_active_nxt;
      asleep <= asleep_nxt;
    end
  end

  // =========================================================
  // checks
  // =========================================================
  sequence s_entry_start;
    state_r == srtc_pkg::SRTC_ST_RUN && !sleep_n_s && sup_s;
  endsequence

  // enabled cycles spent in entry; saturates so a stuck entry cannot wrap
  logic [7:0] ent_time_r;
  logic [7:0] ent_time_nxt;

  always_comb
  begin
    ent_time_nxt = ent_time_r;
    if (state_r != srtc_pkg::SRTC_ST_ENTER)
      ent_time_nxt = 8'h00;
    else if (ent_time_r != 8'hFF)
      ent_time_nxt = ent_time_r + 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      ent_time_r <= 8'h00;
    else if (clk_en)
      ent_time_r <= ent_time_nxt;
  end

  AST_ENTRY_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_b)
    int'(ent_time_r) <= srtc_pkg::SLEEP_ENTRY_CYCLES)
    else $error("sleep entry overran its bound");
  AST_ENTRY_START: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_entry_start ##0 clk_en |=> state_r == srtc_pkg::SRTC_ST_ENTER)
    else $error("sleep request did not start entry");
  AST_TS_FLOATS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && ts_s |=> ctrl.io_tristate)
    else $error("outputs driven while tristate pin high");
  AST_GSR_RESET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !gsr_n_s |=> !ctrl.core_reset_n)
    else $error("core not held in reset");
  AST_LOAD_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !io_active && !asleep |-> ctrl.io_tristate)
    else $error("pad driven before I/O active");
  AST_ERASED_PULL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && device_erased |=> ctrl.io_tristate && ctrl.io_pullup)
    else $error("erased device pads not pulled up");
  AST_ACTIVE_RUN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_active |-> state_r == srtc_pkg::SRTC_ST_RUN && ctrl.core_powered)
    else $error("active I/O outside run state");
  AST_WAKE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_r == srtc_pkg::SRTC_ST_ENTER && sup_s && clk_en
      |=> state_r inside {srtc_pkg::SRTC_ST_ENTER, srtc_pkg::SRTC_ST_SLEEP})
    else $error("entry sequence interrupted");
  AST_SLEEP_LOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(io_active) |-> $past(state_r) != srtc_pkg::SRTC_ST_SLEEP)
    else $error("woke without wake sequence");
  AST_LOAD_DONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_r == srtc_pkg::SRTC_ST_LOAD && sup_s && !device_erased && clk_en
      && cnt_r == last_of(LOAD_CYCLES) |=> io_active)
    else $error("load time exceeded");

endmodule : srtc_top

// File: testbench/srtc_board.sv
/*
  Board controller model: drives the sleep, global reset and output
  tristate pins from the bench's level requests.
  Assumes the bench changes its requests at the falling clock edge.
*/
`timescale 1ns/1ps

module srtc_board (
  // requests from the bench
  input wire logic want_sleep,
  input wire logic want_reset,
  input wire logic want_float,
  // board control pins
  output logic sleep_request_n,
  output logic global_set_reset_n,
  output logic global_output_tristate
);
  // =========================================================
  // pins
  // =========================================================
  // idle requests leave sleep pulled high, as the board should
  assign sleep_request_n = ~want_sleep;
  assign global_set_reset_n = ~want_reset;
  assign global_output_tristate = want_float;
endmodule : srtc_board

// File: testbench/srtc_top_tb_top.sv
/*
  Self-checking bench for the sleep, reset and tristate sequencer.
  Assumes the short exit and load counts (20) set at the instance below; sleep entry keeps the package's 80 cycles.
*/
`timescale 1ns/1ps

module srtc_top_tb_top;
  logic sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, sv = 1'b0, er = 1'b0, opt = 1'b1;
  logic w_sleep = 1'b0, w_rst = 1'b0, w_flt = 1'b0;
  logic sleep_n, gsr_n, tsa, io_active, asleep;
  srtc_pkg::srtc_ctrl_t ctrl;
  logic [5:0] obs;
  logic [3:0] q[$];
  logic [3:0] nt;
  logic [31:0] rnd = 32'h00000031;
  int failures = 0, n_compared = 0, n;

  always #2.5 sys_clk = ~sys_clk;
  assign obs = {ctrl, io_active, asleep};

  srtc_board board (.want_sleep(w_sleep), .want_reset(w_rst), .want_float(w_flt),
    .sleep_request_n(sleep_n), .global_set_reset_n(gsr_n), .global_output_tristate(tsa));

  srtc_top #(.SLEEP_EXIT_CYCLES(20), .LOAD_CYCLES(20)) dut (.sys_clk(sys_clk),
    .rst_b(rst_b), .clk_en(clk_en), .supplies_valid(sv), .device_erased(er),
    .cfg_tristate_opt(opt), .sleep_request_n(sleep_n), .global_set_reset_n(gsr_n),
    .global_output_tristate(tsa), .ctrl(ctrl), .io_active(io_active), .asleep(asleep));

  // =========================================================
  // helpers
  // =========================================================
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task print_verdict;
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task cmp_bit(input string nm, input logic e, input logic s);
    n_compared++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s exp %b seen %b", nm, e, s);
    end
  endtask : cmp_bit

  // output bits: 5 tristate, 4 pullup, 3 core reset_n, 2 powered, 1 active, 0 asleep
  task note(input logic [2:0] sel, input logic e);
    q.push_back({sel, e});
    @(negedge sys_clk);
  endtask : note

  // bounded wait; a hang ends the run as a failure
  task wait_for(input int sel, input logic v, input int mx);
    n = 0;
    while (obs[sel] !== v && n < mx)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= mx)
    begin
      failures++;
      print_verdict();
    end
  endtask : wait_for

  // =========================================================
  // result watcher
  // =========================================================
  always @(posedge sys_clk)
  begin
    #1;
    if (q.size() > 0)
    begin
      nt = q.pop_front();
      cmp_bit($sformatf("out%0d", nt[3:1]), nt[0], obs[nt[3:1]]);
    end
  end

  // =========================================================
  // main sequence
  // =========================================================
  initial
  begin
    repeat (3) @(negedge sys_clk);
    note(3'h1, 1'b0);
    note(3'h0, 1'b0);
    rst_b = 1'b1;
    rnd = xs(rnd);
    opt = rnd[0];
    repeat (4) @(negedge sys_clk);
    note(3'h5, 1'b1);
    note(3'h4, opt);
    sv = 1'b1;
    wait_for(1, 1'b1, 40);
    cmp_bit("load_time", 1'b1, n >= 20 && n <= 28);
    note(3'h5, 1'b0);
    w_flt = 1'b1;
    repeat (4) @(negedge sys_clk);
    note(3'h5, 1'b1);
    w_flt = 1'b0;
    w_rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    note(3'h3, 1'b0);
    w_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    note(3'h3, 1'b1);
    w_sleep = 1'b1;
    repeat (10) @(negedge sys_clk);
    w_sleep = 1'b0;
    wait_for(0, 1'b1, 90);
    cmp_bit("entry_not_cut", 1'b1, n + 10 >= 80 && n + 10 <= 88);
    note(3'h1, 1'b0);
    wait_for(1, 1'b1, 40);
    cmp_bit("late_wake", 1'b1, n <= 30);
    w_sleep = 1'b1;
    wait_for(0, 1'b1, 100);
    cmp_bit("entry_time", 1'b1, n >= 80 && n <= 88);
    note(3'h2, 1'b0);
    w_sleep = 1'b0;
    wait_for(1, 1'b1, 40);
    cmp_bit("exit_time", 1'b1, n >= 20 && n <= 28);
    note(3'h0, 1'b0);
    er = 1'b1;
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (40) @(negedge sys_clk);
    note(3'h1, 1'b0);
    note(3'h5, 1'b1);
    note(3'h4, 1'b1);
    repeat (3) @(negedge sys_clk);
    print_verdict();
  end
endmodule : srtc_top_tb_top
